// ### logic/adc_backend_link_control_regs.sv
/*
  Back-end control register bank of a multi-channel converter: swap steering
  delay, dither controls, timestamp insertion and the serial link enable, plus
  the link gating, multiframe counter and sample path that these steer.
  Assumes a register access port and sample source on clk; timestamp and
  SYSREF arrive from pins and are synchronised here.
*/
// Function
// - Steering select delayed 0..31, reset seven
// - Delay applies only during core swaps
// - Dither enable bit turns dither on
// - Amplitude bit picks small or large dither
// - Rounding bit picks noise or spurs
// - Timestamp rides sample LSB when enabled
// - Timestamp latency matches sample latency
// - Timestamp at N-field LSB, sample intact
// - Advertise zero control bits always
// - Link enable bit, resets to one
// - Disabled link: reset, power down, gate
// - Disabled link: counter reset, SYSREF ignored
`timescale 1ns/1ps

module adc_backend_link_control_regs
  import ctrl_pkg::*;
#(
  parameter int SW = ADC_SAMPLE_W,
  parameter int NW = LINK_SAMPLE_W,
  parameter int LMFC_LEN = LMFC_PERIOD
)
(
  input wire logic clk,
  input wire logic reset,
  // Register access port
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [DATA_W-1:0] reg_rdata,
  output logic reg_rack,
  // Calibration engine
  input wire logic swap_active,
  input wire logic steer_select_in,
  output logic steer_select_out,
  // Dither controls
  output logic dither_enable,
  output logic dither_amplitude_select,
  output logic dither_rounding_select,
  // Sample path
  input wire logic [SW-1:0] adc_sample,
  input wire logic adc_sample_valid,
  input wire logic timestamp_pin,
  output logic [NW-1:0] link_sample,
  output logic link_sample_valid,
  // Link subsystem
  input wire logic sysref_pin,
  output logic link_subsystem_enable,
  output logic [LINK_MODE_W-1:0] link_mode_select,
  output logic link_block_reset,
  output logic serializer_power_down,
  output logic link_clock_enable,
  output logic [$clog2(LMFC_LEN)-1:0] lmfc_count,
  output logic lmfc_boundary,
  output logic [3:0] ila_control_bits
);

  // ==========================================================
  // Register storage
  logic [STEER_DELAY_W-1:0] steer_delay_r;  // Swap steering delay
  logic [DITHER_W-1:0] dither_r;            // Dither controls
  logic ts_enable_r;                        // Timestamp insertion enable
  logic link_enable_r;                      // Link subsystem enable
  logic [LINK_MODE_W-1:0] link_mode_r;      // Link mode select
  logic [DATA_W-1:0] rdata_nxt;             // Read mux result

  // Register hit helper
  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] ofs);
    hit = (a == ofs);
  endfunction

  // Steering delay register; reserved bits are not stored
  always_ff @(posedge clk)
  begin
    if (reset)
      steer_delay_r <= RST_STEER_DELAY;
    else if (reg_wr && hit(reg_addr, OFS_SWAP_STEER_DELAY))
      steer_delay_r <= reg_wdata[STEER_DELAY_W-1:0];
  end

  // Dither register
  always_ff @(posedge clk)
  begin
    if (reset)
      dither_r <= RST_DITHER;
    else if (reg_wr && hit(reg_addr, OFS_DITHER_CONTROL))
      dither_r <= reg_wdata[DITHER_W-1:0];
  end

  // Timestamp control register
  always_ff @(posedge clk)
  begin
    if (reset)
      ts_enable_r <= RST_TS_EN;
    else if (reg_wr && hit(reg_addr, OFS_TIMESTAMP_LSB_CONTROL))
      ts_enable_r <= reg_wdata[TS_EN_BIT];
  end

  // Link subsystem enable register
  always_ff @(posedge clk)
  begin
    if (reset)
      link_enable_r <= RST_LINK_EN;
    else if (reg_wr && hit(reg_addr, OFS_LINK_SUBSYSTEM_ENABLE))
      link_enable_r <= reg_wdata[LINK_EN_BIT];
  end

  // Link mode register; ordering against enables is software's duty
  always_ff @(posedge clk)
  begin
    if (reset)
      link_mode_r <= RST_LINK_MODE;
    else if (reg_wr && hit(reg_addr, OFS_LINK_MODE_SELECT))
      link_mode_r <= reg_wdata[LINK_MODE_W-1:0];
  end

  // ==========================================================
  // Read path
  always_comb
  begin
    rdata_nxt = '0;                         // Unmapped and reserved read zero
    if (hit(reg_addr, OFS_SWAP_STEER_DELAY))
      rdata_nxt[STEER_DELAY_W-1:0] = steer_delay_r;
    else if (hit(reg_addr, OFS_DITHER_CONTROL))
      rdata_nxt[DITHER_W-1:0] = dither_r;
    else if (hit(reg_addr, OFS_TIMESTAMP_LSB_CONTROL))
      rdata_nxt[TS_EN_BIT] = ts_enable_r;
    else if (hit(reg_addr, OFS_LINK_SUBSYSTEM_ENABLE))
      rdata_nxt[LINK_EN_BIT] = link_enable_r;
    else if (hit(reg_addr, OFS_LINK_MODE_SELECT))
      rdata_nxt[LINK_MODE_W-1:0] = link_mode_r;
  end

  // Read data and acknowledge, one cycle after the request
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      reg_rdata <= '0;
      reg_rack <= 1'b0;
    end
    else
    begin
      reg_rack <= reg_rd;
      if (reg_rd)
        reg_rdata <= rdata_nxt;
    end
  end

  // ==========================================================
  // Dither and link control outputs
  assign dither_enable = dither_r[DITHER_EN_BIT];
  assign dither_amplitude_select = dither_r[DITHER_AMP_BIT];
  assign dither_rounding_select = dither_r[DITHER_ERR_BIT];
  assign link_subsystem_enable = link_enable_r;
  assign link_mode_select = link_mode_r;
  assign ila_control_bits = ILA_CONTROL_BITS;

  // Link gating follows the enable directly
  assign link_block_reset = !link_enable_r;
  assign serializer_power_down = !link_enable_r;
  assign link_clock_enable = link_enable_r;

  // ==========================================================
  // Configuration carrier for the helpers
  cfg_if cfg ();
  assign cfg.steer_delay = steer_delay_r;
  assign cfg.ts_enable = ts_enable_r;
  assign cfg.link_enable = link_enable_r;

  // ==========================================================
  // Pin synchronisers
  logic [SYNC_STAGES-1:0] ts_sync_r;        // Timestamp synchroniser
  logic [SYNC_STAGES-1:0] sysref_sync_r;    // SYSREF synchroniser
  logic sysref_prev_r;                      // Last synchronised SYSREF
  logic sysref_rise;                        // SYSREF rising edge

  // Two flops per pin; only the last stage is read
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      ts_sync_r <= '0;
      sysref_sync_r <= '0;
      sysref_prev_r <= 1'b0;
    end
    else
    begin
      ts_sync_r <= {ts_sync_r[SYNC_STAGES-2:0], timestamp_pin};
      sysref_sync_r <= {sysref_sync_r[SYNC_STAGES-2:0], sysref_pin};
      sysref_prev_r <= sysref_sync_r[SYNC_STAGES-1];
    end
  end

  assign sysref_rise = sysref_sync_r[SYNC_STAGES-1] && !sysref_prev_r;

  // ==========================================================
  // Multiframe counter
  localparam logic [$clog2(LMFC_LEN)-1:0] LMFC_LAST = ($clog2(LMFC_LEN))'(LMFC_LEN - 1);

  // Held in reset while the link is off; SYSREF realigns only when on
  always_ff @(posedge clk)
  begin
    if (reset || !link_enable_r)
      lmfc_count <= '0;
    else if (sysref_rise)
      lmfc_count <= '0;
    else if (lmfc_count == LMFC_LAST)
      lmfc_count <= '0;
    else
      lmfc_count <= lmfc_count + 1'b1;
  end

  assign lmfc_boundary = link_enable_r && (lmfc_count == '0);

  // ==========================================================
  // Sample alignment to the synchronised timestamp
  logic [SW-1:0] sample_pipe_r [SYNC_STAGES];   // Sample delay line
  logic [SYNC_STAGES-1:0] valid_pipe_r;         // Valid delay line

  // Delay samples by the synchroniser depth so both stay aligned
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      for (int i = 0; i < SYNC_STAGES; i++)
        sample_pipe_r[i] <= '0;
      valid_pipe_r <= '0;
    end
    else
    begin
      sample_pipe_r[0] <= adc_sample;
      for (int i = 1; i < SYNC_STAGES; i++)
        sample_pipe_r[i] <= sample_pipe_r[i-1];
      valid_pipe_r <= {valid_pipe_r[SYNC_STAGES-2:0], adc_sample_valid};
    end
  end

  // ==========================================================
  // Helpers
  swap_steer_delay_unit u_steer
  (
    .clk(clk),
    .reset(reset),
    .cfg(cfg),
    .swap_active(swap_active),
    .select_in(steer_select_in),
    .select_out(steer_select_out)
  );

  timestamp_insert_unit #(.SW(SW), .NW(NW)) u_ts
  (
    .clk(clk),
    .reset(reset),
    .cfg(cfg),
    .sample_in(sample_pipe_r[SYNC_STAGES-1]),
    .sample_valid_in(valid_pipe_r[SYNC_STAGES-1]),
    .timestamp_in(ts_sync_r[SYNC_STAGES-1]),
    .link_sample(link_sample),
    .link_sample_valid(link_sample_valid)
  );

endmodule // adc_backend_link_control_regs

// ### logic/cfg_if.sv
/*
  Interface carrying the live configuration from the register bank to its helpers.
  Assumes a single clock domain; the bank drives, helpers only read.
*/
`timescale 1ns/1ps

interface cfg_if;
  import ctrl_pkg::*;

  logic [STEER_DELAY_W-1:0] steer_delay;    // Programmed steering delay
  logic ts_enable;                          // Timestamp insertion on
  logic link_enable;                        // Link subsystem running

  // Register bank side
  modport src (output steer_delay, output ts_enable, output link_enable);
  // Helper side
  modport dst (input steer_delay, input ts_enable, input link_enable);
endinterface

// ### logic/ctrl_pkg.sv
/*
  Constants shared by the back-end control register bank and its helpers:
  register offsets, field positions, widths, reset values and pipeline figures.
  Assumes nothing of its surroundings; compiled before every design file.
*/
package ctrl_pkg;

  // ==========================================================
  // Register access port geometry
  localparam int ADDR_W = 12;               // Register address width
  localparam int DATA_W = 8;                // Register data width

  // ==========================================================
  // Register offsets
  localparam logic [ADDR_W-1:0] OFS_SWAP_STEER_DELAY = 12'h09b;
  localparam logic [ADDR_W-1:0] OFS_DITHER_CONTROL = 12'h09d;
  localparam logic [ADDR_W-1:0] OFS_TIMESTAMP_LSB_CONTROL = 12'h160;
  localparam logic [ADDR_W-1:0] OFS_LINK_SUBSYSTEM_ENABLE = 12'h200;
  localparam logic [ADDR_W-1:0] OFS_LINK_MODE_SELECT = 12'h201;

  // ==========================================================
  // Field layouts
  localparam int STEER_DELAY_W = 5;         // Delay field, bits 4:0
  localparam int STEER_DELAY_MAX = 31;      // Largest programmable delay
  localparam int DITHER_EN_BIT = 0;         // Dither on/off
  localparam int DITHER_AMP_BIT = 1;        // Small or large dither
  localparam int DITHER_ERR_BIT = 2;        // Rounding error destination
  localparam int DITHER_W = 3;              // Defined dither bits 2:0
  localparam int TS_EN_BIT = 0;             // Timestamp insertion enable
  localparam int LINK_EN_BIT = 0;           // Link subsystem enable
  localparam int LINK_MODE_W = 6;           // Link mode field, bits 5:0

  // ==========================================================
  // Reset values
  localparam logic [STEER_DELAY_W-1:0] RST_STEER_DELAY = 5'h07;
  localparam logic [DITHER_W-1:0] RST_DITHER = 3'h0;
  localparam logic RST_TS_EN = 1'b0;
  localparam logic RST_LINK_EN = 1'b1;
  localparam logic [LINK_MODE_W-1:0] RST_LINK_MODE = 6'h00;

  // ==========================================================
  // Data path figures
  localparam int ADC_SAMPLE_W = 9;          // Converter sample width
  localparam int LINK_SAMPLE_W = 16;        // Link sample field width N
  localparam int SYNC_STAGES = 2;           // Pin synchroniser depth
  localparam int LMFC_PERIOD = 32;          // Frames per multiframe
  localparam logic [3:0] ILA_CONTROL_BITS = 4'h0; // Advertised control bits

endpackage

// ### logic/swap_steer_delay_unit.sv
/*
  Delays the core-output steering select by a programmed number of cycles
  while a background core swap is under way; passes it straight otherwise.
  Assumes select and swap flag come from logic on the same clock.
*/
`timescale 1ns/1ps

module swap_steer_delay_unit
  import ctrl_pkg::*;
#(
  parameter int DEPTH = STEER_DELAY_MAX + 1
)
(
  input wire logic clk,
  input wire logic reset,
  cfg_if.dst cfg,
  input wire logic swap_active,
  input wire logic select_in,
  output logic select_out
);

  // ==========================================================
  // Select history
  logic [DEPTH-1:0] hist_r;                 // Bit k is select k+1 cycles ago
  logic delayed;                            // Tapped select

  // Shift in the raw select every cycle
  always_ff @(posedge clk)
  begin
    if (reset)
      hist_r <= '0;
    else
      hist_r <= {hist_r[DEPTH-2:0], select_in};
  end

  // ==========================================================
  // Tap selection: zero delay is the raw select
  always_comb
  begin
    if (cfg.steer_delay == '0)
      delayed = select_in;
    else
      delayed = hist_r[cfg.steer_delay - 1'b1];
  end

  // Delay only counts during a swap
  always_comb
  begin
    if (swap_active)
      select_out = delayed;
    else
      select_out = select_in;
  end

endmodule // swap_steer_delay_unit

// ### logic/timestamp_insert_unit.sv
/*
  Packs a converter sample into the N-bit link sample field and optionally
  places the timestamp bit at the field's lowest bit.
  Assumes sample and timestamp arrive already aligned to one another.
*/
`timescale 1ns/1ps

module timestamp_insert_unit
  import ctrl_pkg::*;
#(
  parameter int SW = ADC_SAMPLE_W,
  parameter int NW = LINK_SAMPLE_W
)
(
  input wire logic clk,
  input wire logic reset,
  cfg_if.dst cfg,
  input wire logic [SW-1:0] sample_in,
  input wire logic sample_valid_in,
  input wire logic timestamp_in,
  output logic [NW-1:0] link_sample,
  output logic link_sample_valid
);

  // ==========================================================
  // Field packing
  logic [NW-1:0] field;                     // Sample left-aligned in field

  // Left-align the sample, then drop the timestamp on bit 0
  always_comb
  begin
    field = NW'(sample_in) << (NW - SW);
    if (cfg.ts_enable)
      field[0] = timestamp_in;
  end

  // Registered output; quiet while the link is off
  always_ff @(posedge clk)
  begin
    if (reset || !cfg.link_enable)
    begin
      link_sample <= '0;
      link_sample_valid <= 1'b0;
    end
    else
    begin
      link_sample <= field;
      link_sample_valid <= sample_valid_in;
    end
  end

endmodule // timestamp_insert_unit

// ### test/adc_backend_link_control_regs_assertions.sv
/*
  Port-level checker for the back-end control register bank.
  Assumes one clock and a synchronous active-high reset; bound to the design below.
*/
`timescale 1ns/1ps

module adc_backend_link_control_regs_assertions
  import ctrl_pkg::*;
#(
  parameter int SW = ADC_SAMPLE_W,
  parameter int NW = LINK_SAMPLE_W,
  parameter int LMFC_LEN = LMFC_PERIOD
)
(
  input wire logic clk,
  input wire logic reset,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic reg_rack,
  input wire logic swap_active,
  input wire logic steer_select_in,
  input wire logic steer_select_out,
  input wire logic dither_enable,
  input wire logic dither_amplitude_select,
  input wire logic dither_rounding_select,
  input wire logic [SW-1:0] adc_sample,
  input wire logic adc_sample_valid,
  input wire logic [NW-1:0] link_sample,
  input wire logic link_sample_valid,
  input wire logic link_subsystem_enable,
  input wire logic link_block_reset,
  input wire logic serializer_power_down,
  input wire logic link_clock_enable,
  input wire logic [$clog2(LMFC_LEN)-1:0] lmfc_count,
  input wire logic [3:0] ila_control_bits
);
  // ==========================================================
  // Helper logic
  logic [DATA_W-1:0] wdata_r; // Write data of the previous cycle

  // Keep last write data for the write checks
  always_ff @(posedge clk)
  begin
    wdata_r <= reg_wdata;
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);

  // ==========================================================
  // Properties
  AST_STEER_PASS: assert property (
    !swap_active |-> steer_select_out == steer_select_in)
    else $error("steering select altered outside a swap");
  AST_DITHER_WRITE: assert property (
    reg_wr && reg_addr == OFS_DITHER_CONTROL |=>
    {dither_rounding_select, dither_amplitude_select, dither_enable} == wdata_r[2:0])
    else $error("dither pins do not follow write");
  AST_LINK_WRITE: assert property (
    reg_wr && reg_addr == OFS_LINK_SUBSYSTEM_ENABLE |=> link_subsystem_enable == wdata_r[0])
    else $error("link enable does not follow write");
  AST_LINK_GATING: assert property (
    link_block_reset == !link_subsystem_enable && serializer_power_down == !link_subsystem_enable
    && link_clock_enable == link_subsystem_enable)
    else $error("link gating does not match enable");
  AST_LMFC_HELD: assert property (
    !link_subsystem_enable ##1 !link_subsystem_enable |-> lmfc_count == '0)
    else $error("multiframe counter runs while link disabled");
  AST_OUT_QUIET: assert property (
    !link_subsystem_enable ##1 !link_subsystem_enable |-> !link_sample_valid && link_sample == '0)
    else $error("samples leave while link disabled");
  AST_ILA_ZERO: assert property (
    ila_control_bits == 4'h0)
    else $error("nonzero control bits advertised");
  AST_READ_ACK: assert property (
    reg_rd |=> reg_rack)
    else $error("read not acknowledged");
  AST_ACK_CAUSE: assert property (
    reg_rack |-> $past(reg_rd))
    else $error("acknowledge without read");
  AST_SAMPLE_LAT: assert property (
    link_subsystem_enable [*4] |-> link_sample_valid == $past(adc_sample_valid, 3))
    else $error("sample valid latency wrong");
  AST_SAMPLE_PLACE: assert property (
    link_subsystem_enable [*4] ##0 link_sample_valid |->
    link_sample[NW-1:NW-SW] == $past(adc_sample, 3) && link_sample[NW-SW-1:1] == '0)
    else $error("sample bits misplaced in link field");
endmodule // adc_backend_link_control_regs_assertions

bind adc_backend_link_control_regs adc_backend_link_control_regs_assertions
  #(.SW(SW), .NW(NW), .LMFC_LEN(LMFC_LEN)) chk (
  .clk(clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rack(reg_rack), .swap_active(swap_active),
  .steer_select_in(steer_select_in), .steer_select_out(steer_select_out),
  .dither_enable(dither_enable), .dither_amplitude_select(dither_amplitude_select),
  .dither_rounding_select(dither_rounding_select), .adc_sample(adc_sample),
  .adc_sample_valid(adc_sample_valid), .link_sample(link_sample),
  .link_sample_valid(link_sample_valid), .link_subsystem_enable(link_subsystem_enable),
  .link_block_reset(link_block_reset), .serializer_power_down(serializer_power_down),
  .link_clock_enable(link_clock_enable), .lmfc_count(lmfc_count),
  .ila_control_bits(ila_control_bits));

// ### test/adc_backend_link_control_regs_bench.sv
/*
  Self-checking bench for the back-end control register bank.
  Assumes the checker is bound to the design; all inputs change at falling edges.
*/
`timescale 1ns/1ps

module adc_backend_link_control_regs_bench;
  import ctrl_pkg::*;

  // ==========================================================
  // Signals
  localparam int LMFC = 32; // Multiframe length used here
  logic clk = 1'b0, reset = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, reg_rack;
  logic [ADDR_W-1:0] reg_addr = '0;
  logic [DATA_W-1:0] reg_wdata = '0, reg_rdata;
  logic swap_active = 1'b0, steer_select_in = 1'b0, steer_select_out;
  logic dither_enable, dither_amplitude_select, dither_rounding_select;
  logic [ADC_SAMPLE_W-1:0] adc_sample = '0;
  logic adc_sample_valid = 1'b0, timestamp_pin = 1'b0, sysref_pin = 1'b0;
  logic [LINK_SAMPLE_W-1:0] link_sample;
  logic link_sample_valid, link_subsystem_enable, link_block_reset;
  logic serializer_power_down, link_clock_enable, lmfc_boundary;
  logic [LINK_MODE_W-1:0] link_mode_select;
  logic [$clog2(LMFC)-1:0] lmfc_count;
  logic [3:0] ila_control_bits;
  int err_total = 0, tests_run = 0, cycles = 0; // Counters
  int seed = 32'h52d8_a79d; // Fixed seed

  adc_backend_link_control_regs #(.LMFC_LEN(LMFC)) dut (
    .clk(clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rack(reg_rack), .swap_active(swap_active),
    .steer_select_in(steer_select_in), .steer_select_out(steer_select_out),
    .dither_enable(dither_enable), .dither_amplitude_select(dither_amplitude_select),
    .dither_rounding_select(dither_rounding_select), .adc_sample(adc_sample),
    .adc_sample_valid(adc_sample_valid), .timestamp_pin(timestamp_pin),
    .link_sample(link_sample), .link_sample_valid(link_sample_valid), .sysref_pin(sysref_pin),
    .link_subsystem_enable(link_subsystem_enable), .link_mode_select(link_mode_select),
    .link_block_reset(link_block_reset), .serializer_power_down(serializer_power_down),
    .link_clock_enable(link_clock_enable), .lmfc_count(lmfc_count),
    .lmfc_boundary(lmfc_boundary), .ila_control_bits(ila_control_bits));

  // Clock and hang guard
  always #12.5 clk = ~clk;
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 5000)
    begin
      err_total++;
      finish_test;
    end
  end

  // ==========================================================
  // Tasks and expectation functions
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic finish_test;
    $display("Checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic reg_write(input logic [ADDR_W-1:0] a, input logic [7:0] d);
    @(negedge clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge clk);
    reg_wr = 1'b0;
  endtask

  task automatic reg_read(input logic [ADDR_W-1:0] a, output logic [7:0] d);
    @(negedge clk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge clk);
    reg_rd = 1'b0;
    check("read ack", reg_rack, 1);
    d = reg_rdata;
  endtask

  // Defined bits of each register
  function automatic logic [7:0] reg_mask(input logic [ADDR_W-1:0] a);
    case (a)
      OFS_SWAP_STEER_DELAY: return 8'h1f;
      OFS_DITHER_CONTROL: return 8'h07;
      OFS_LINK_MODE_SELECT: return 8'h3f;
      OFS_TIMESTAMP_LSB_CONTROL, OFS_LINK_SUBSYSTEM_ENABLE: return 8'h01;
      default: return 8'h00;
    endcase
  endfunction

  // Link field from {valid, pin, sample}
  function automatic logic [LINK_SAMPLE_W-1:0] exp_sample(input logic [10:0] e, input logic ts);
    return (LINK_SAMPLE_W'(e[8:0]) << (LINK_SAMPLE_W - ADC_SAMPLE_W)) | LINK_SAMPLE_W'(ts & e[9]);
  endfunction

  // ==========================================================
  // Main sequence
  initial
  begin : main
    logic [ADDR_W-1:0] regs [5] = '{OFS_SWAP_STEER_DELAY, OFS_DITHER_CONTROL,
      OFS_TIMESTAMP_LSB_CONTROL, OFS_LINK_SUBSYSTEM_ENABLE, OFS_LINK_MODE_SELECT};
    logic [7:0] rst_val [5] = '{8'h07, 8'h00, 8'h00, 8'h01, 8'h00};
    logic [7:0] v, got;
    logic [31:0] r;
    logic hist [$];
    logic [10:0] sq [$];
    int d, run;
    repeat (16) @(negedge clk);
    reset = 1'b0;
    // Reset values, then an unmapped place
    for (int i = 0; i < 5; i++)
    begin
      reg_read(regs[i], got);
      check("reset value", got, rst_val[i]);
    end
    reg_read(12'h09c, got);
    check("unmapped read", got, 0);
    // Random and all-ones writes, reserved bits kept zero by software
    for (int k = 0; k < 20; k++)
    begin
      r = $random(seed);
      v = ((k < 5) ? 8'hff : r[7:0]) & reg_mask(regs[k % 5]);
      // Link goes quiet before its mode is touched
      if (k % 5 == 4) reg_write(OFS_LINK_SUBSYSTEM_ENABLE, 8'h00);
      reg_write(regs[k % 5], v);
      if (k % 5 == 3) check("link pin", link_subsystem_enable, v[0]);
      if (k % 5 == 4) check("mode pin", link_mode_select, v[5:0]);
      reg_read(regs[k % 5], got);
      check("readback", got, v & reg_mask(regs[k % 5]));
    end
    // Every dither code
    for (int k = 0; k < 8; k++)
    begin
      reg_write(OFS_DITHER_CONTROL, 8'(k));
      check("dither pins", {dither_rounding_select, dither_amplitude_select, dither_enable}, k[2:0]);
    end
    // Link back on for the steering and sample path tests
    reg_write(OFS_LINK_SUBSYSTEM_ENABLE, 8'h01);
    // Steering delay at both ends and one random value
    for (int j = 0; j < 3; j++)
    begin
      r = $random(seed);
      d = (j == 0) ? 0 : (j == 1) ? 31 : int'(r[4:0]);
      reg_write(OFS_SWAP_STEER_DELAY, 8'(d));
      hist = {};
      run = 0;
      for (int i = 0; i < 90; i++)
      begin
        @(negedge clk);
        r = $random(seed);
        swap_active = (i >= 10 && i < 80);
        steer_select_in = r[0];
        hist.push_front(r[0]);
        run = swap_active ? run + 1 : 0;
        #1;
        if (!swap_active) check("steer pass", steer_select_out, steer_select_in);
        else if (run > d) check("steer delayed", steer_select_out, hist[d]);
      end
    end
    // Sample path with timestamp insertion off, then on
    for (int t = 0; t < 2; t++)
    begin
      // Timestamp receiver enable lives outside this bank
      reg_write(OFS_TIMESTAMP_LSB_CONTROL, 8'(t));
      sq = {};
      for (int i = 0; i < 40; i++)
      begin
        @(negedge clk);
        if (sq.size() > 2) check("sample valid", link_sample_valid, sq[2][10]);
        if (sq.size() > 2 && sq[2][10]) check("link sample", link_sample, exp_sample(sq[2], t[0]));
        r = $random(seed);
        adc_sample = r[8:0];
        adc_sample_valid = r[9];
        timestamp_pin = r[10];
        sq.push_front({r[9], r[10], r[8:0]});
      end
    end
    // Link disabled: held quiet while SYSREF toggles
    reg_write(OFS_LINK_SUBSYSTEM_ENABLE, 8'h00);
    for (int i = 0; i < 24; i++)
    begin
      @(negedge clk);
      r = $random(seed);
      sysref_pin = r[0];
      adc_sample_valid = 1'b1;
      if (i > 1) check("held link", {link_block_reset, serializer_power_down, link_clock_enable, link_sample_valid, lmfc_count}, {4'b1100, 5'h00});
    end
    check("control bits", ila_control_bits, 0);
    // Enabled again: SYSREF rise realigns the counter
    sysref_pin = 1'b0;
    reg_write(OFS_LINK_SUBSYSTEM_ENABLE, 8'h01);
    repeat (45) @(negedge clk);
    sysref_pin = 1'b1;
    repeat (3) @(negedge clk);
    check("counter realign", lmfc_count, 0);
    check("boundary flag", lmfc_boundary, 1);
    repeat (LMFC + 5) @(negedge clk);
    check("counter wrap", lmfc_count, 5);
    finish_test;
  end
endmodule // adc_backend_link_control_regs_bench
